// >>> common/aperture_ctrl_pkg.sv
/*
 * constants for the graphics aperture control register bank.
 * assumes a byte-addressed configuration space and one 200 MHz clock.
 */
package aperture_ctrl_pkg;
	// ==========================================================
	// offsets
	localparam logic [7:0]  PORT_CONTROL_OFFSET  = 8'hb0;
	localparam logic [7:0]  APERTURE_SIZE_OFFSET = 8'hb4;
	// ==========================================================
	// reset values
	localparam logic [31:0] PORT_CONTROL_RESET   = 32'h0000_0000;
	localparam logic [7:0]  APERTURE_SIZE_RESET  = 8'h00;
	// ==========================================================
	// fields
	localparam int          TB_ENABLE_BIT        = 7;
	localparam int          RATE_OVERRIDE_BIT    = 0;
	localparam logic [31:0] PORT_CONTROL_WMASK   = 32'h0000_0081;
	localparam logic [7:0]  SIZE_MASK_WMASK      = 8'h3f;
	localparam int          BASE_MASK_LSB        = 22;
	localparam int          SIZE_MASK_WIDTH      = 6;
	localparam logic [2:0]  RATE_ALL             = 3'h7;
	localparam logic [2:0]  RATE_1X_ONLY         = 3'h1;
	// ==========================================================
	// translation buffer
	localparam int          TB_ENTRIES           = 8;
	localparam int          TB_TAG_WIDTH         = 10;
	localparam int          TB_IDX_WIDTH         = 3;
	localparam int          TB_PAGE_WIDTH        = 20;
endpackage

// >>> dv/aperture_control_regs_tb_top.sv
/*
 * self-checking bench for the aperture control register bank.
 * assumes the package constants, one 200 MHz clock, sync reset.
 */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	$display("mismatch %s exp %h got %h", nm, ex, got); fails++; end end
module aperture_control_regs_tb_top;
	import aperture_ctrl_pkg::*;
	logic                     sys_clk = 0;
	logic                     reset, cfg_write, cfg_read, base_write;
	logic                     fill_valid;
	logic [7:0]               cfg_offset;
	logic [31:0]              cfg_wdata, cfg_rdata, d;
	logic [5:0]               base_wdata, aperture_base_bits, m_base;
	logic [TB_TAG_WIDTH-1:0]  fill_tag, lookup_tag;
	logic [TB_PAGE_WIDTH-1:0] fill_page, lookup_page;
	logic [2:0]               status_rate;
	logic                     translation_buffer_enable, lookup_hit;
	logic [31:0]              m_ctrl = 0;
	logic [7:0]               m_size = 0;
	logic [15:0]              lfsr = 16'h0049;
	logic [9:0]               q_tag[$];
	logic [19:0]              q_page[$];
	logic [7:0]               size_pat[8] = '{8'h3f, 8'h3e, 8'h3c, 8'h38,
	                                          8'h30, 8'h20, 8'h00, 8'hff};
	int                       fails = 0, n_tests = 0;
	always #2.5 sys_clk = ~sys_clk;
	aperture_control_regs i_dut (
		.sys_clk                   (sys_clk),
		.reset                     (reset),
		.cfg_write                 (cfg_write),
		.cfg_read                  (cfg_read),
		.cfg_offset                (cfg_offset),
		.cfg_wdata                 (cfg_wdata),
		.base_write                (base_write),
		.base_wdata                (base_wdata),
		.fill_valid                (fill_valid),
		.fill_tag                  (fill_tag),
		.fill_page                 (fill_page),
		.lookup_tag                (lookup_tag),
		.cfg_rdata                 (cfg_rdata),
		.status_rate               (status_rate),
		.aperture_base_bits        (aperture_base_bits),
		.translation_buffer_enable (translation_buffer_enable),
		.lookup_hit                (lookup_hit),
		.lookup_page               (lookup_page)
	);
	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd32();
		for (int k = 0; k < 32; k++)
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return {lfsr, lfsr[7:0], lfsr[15:8]};
	endfunction
	task automatic chk_outs();
		`CHK("rate", m_ctrl[0] ? RATE_1X_ONLY : RATE_ALL, status_rate)
		`CHK("enable", m_ctrl[7], translation_buffer_enable)
		`CHK("base", m_base, aperture_base_bits)
	endtask
	task automatic wr(input logic [7:0] off, input logic [31:0] w);
		@(posedge sys_clk);
		cfg_write <= 1;
		cfg_offset <= off;
		cfg_wdata <= w;
		@(posedge sys_clk);
		cfg_write <= 0;
		if (off == PORT_CONTROL_OFFSET) begin
			if (!w[7]) begin
				q_tag = {};
				q_page = {};
			end
			m_ctrl = w & PORT_CONTROL_WMASK;
		end
		if (off == APERTURE_SIZE_OFFSET) begin
			m_size = w[7:0] & SIZE_MASK_WMASK;
			m_base = m_base & m_size[5:0];
		end
		#1 chk_outs();
	endtask
	task automatic rd(input logic [7:0] off);
		logic [31:0] e;
		e = 32'h0000_0000;
		if (off == PORT_CONTROL_OFFSET) e = m_ctrl;
		if (off == APERTURE_SIZE_OFFSET) e = {24'h00_0000, m_size};
		@(posedge sys_clk);
		cfg_read <= 1;
		cfg_offset <= off;
		@(posedge sys_clk);
		cfg_read <= 0;
		#1;
		`CHK("rdata", e, cfg_rdata)
		// read data stands one cycle only
		@(posedge sys_clk);
		#1;
		`CHK("rdata idle", 32'h0000_0000, cfg_rdata)
	endtask
	task automatic bw(input logic [5:0] w);
		@(posedge sys_clk);
		base_write <= 1;
		base_wdata <= w;
		@(posedge sys_clk);
		base_write <= 0;
		m_base = w & m_size[5:0];
		#1 chk_outs();
	endtask
	task automatic fill(input logic [9:0] t);
		d = rnd32();
		@(posedge sys_clk);
		fill_valid <= 1;
		fill_tag <= t;
		fill_page <= d[19:0];
		@(posedge sys_clk);
		fill_valid <= 0;
		if (m_ctrl[7]) begin
			q_tag.push_back(t);
			q_page.push_back(d[19:0]);
		end
	endtask
	task automatic look(input logic [9:0] t);
		logic       h;
		logic [19:0] p;
		h = 0;
		p = 0;
		@(posedge sys_clk);
		lookup_tag <= t;
		repeat (2) @(posedge sys_clk);
		#1;
		foreach (q_tag[k]) begin
			if (q_tag[k] == t && m_ctrl[7]) begin
				h = 1;
				p = q_page[k];
			end
		end
		`CHK("hit", h, lookup_hit)
		`CHK("page", p, lookup_page)
	endtask
	// ==========================================================
	// verdict
	task automatic summarize();
		if (fails == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// a hang shows up long before this span runs out
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		summarize();
	end
	// ==========================================================
	// main sequence
	initial begin
		{cfg_write, cfg_read, base_write, fill_valid} = 0;
		{cfg_offset, cfg_wdata, base_wdata, fill_tag, fill_page} = 0;
		lookup_tag = 0;
		m_base = 0;
		reset = 1;
		repeat (8) @(posedge sys_clk);
		reset <= 0;
		@(posedge sys_clk);
		#1 chk_outs();
		rd(PORT_CONTROL_OFFSET);
		rd(APERTURE_SIZE_OFFSET);
		wr(8'hb8, rnd32());
		rd(8'hb8);
		wr(PORT_CONTROL_OFFSET, 32'hffff_ffff);
		rd(PORT_CONTROL_OFFSET);
		for (int i = 0; i < 4; i++) begin
			wr(PORT_CONTROL_OFFSET, rnd32());
			rd(PORT_CONTROL_OFFSET);
		end
		foreach (size_pat[i]) begin
			d = rnd32();
			wr(APERTURE_SIZE_OFFSET, {d[31:8], size_pat[i]});
			rd(APERTURE_SIZE_OFFSET);
			bw(6'h3f);
			bw(d[5:0]);
		end
		wr(PORT_CONTROL_OFFSET, 32'h80);
		for (int i = 0; i < 5; i++) fill(10'(i * 37 + 1));
		for (int i = 0; i < 6; i++) look(10'(i * 37 + 1));
		wr(PORT_CONTROL_OFFSET, 32'h1);
		look(10'd38);
		fill(10'd300);
		wr(PORT_CONTROL_OFFSET, 32'h81);
		look(10'd300);
		look(10'd75);
		fill(10'd500);
		look(10'd500);
		@(posedge sys_clk);
		reset <= 1;
		repeat (2) @(posedge sys_clk);
		reset <= 0;
		m_ctrl = 0;
		m_size = 0;
		m_base = 0;
		q_tag = {};
		q_page = {};
		@(posedge sys_clk);
		#1 chk_outs();
		rd(PORT_CONTROL_OFFSET);
		rd(APERTURE_SIZE_OFFSET);
		look(10'd500);
		summarize();
	end
endmodule // aperture_control_regs_tb_top

// >>> hw/aperture_control_regs.sv
/*
 * port control and aperture size registers with their effects:
 * translation buffer enable/flush, rate override, base bit masking.
 * assumes a simple single-cycle configuration access port.
 */
`timescale 1ns/100ps
module aperture_control_regs
	import aperture_ctrl_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	input  wire logic                     cfg_write,
	input  wire logic                     cfg_read,
	input  wire logic [7:0]               cfg_offset,
	input  wire logic [31:0]              cfg_wdata,
	input  wire logic                     base_write,
	input  wire logic [5:0]               base_wdata,
	input  wire logic                     fill_valid,
	input  wire logic [TB_TAG_WIDTH-1:0]  fill_tag,
	input  wire logic [TB_PAGE_WIDTH-1:0] fill_page,
	input  wire logic [TB_TAG_WIDTH-1:0]  lookup_tag,
	output logic [31:0]                   cfg_rdata,
	output logic [2:0]                    status_rate,
	output logic [5:0]                    aperture_base_bits,
	output logic                          translation_buffer_enable,
	output logic                          lookup_hit,
	output logic [TB_PAGE_WIDTH-1:0]      lookup_page
);
	logic [31:0]              port_control_reg;
	logic [31:0]              next_port_control_reg;
	logic [7:0]               aperture_size_mask;
	logic [7:0]               next_aperture_size_mask;
	logic [5:0]               base_store;
	logic [5:0]               next_base_store;
	logic [31:0]              next_cfg_rdata;
	logic [2:0]               next_status_rate;
	logic                     tb_hit;
	logic [TB_PAGE_WIDTH-1:0] tb_page;
	logic                     tb_any_valid;

	// ==========================================================
	// register writes
	always_comb begin
		next_port_control_reg   = port_control_reg;
		next_aperture_size_mask = aperture_size_mask;
		next_base_store         = base_store;
		if (cfg_write && cfg_offset == PORT_CONTROL_OFFSET) begin
			next_port_control_reg = cfg_wdata & PORT_CONTROL_WMASK;
		end
		if (cfg_write && cfg_offset == APERTURE_SIZE_OFFSET) begin
			next_aperture_size_mask = cfg_wdata[7:0] & SIZE_MASK_WMASK;
		end
		// base bits stored where mask allows
		if (base_write) begin
			next_base_store = base_wdata;
		end
		// masked base bits held at zero
		next_base_store = next_base_store
			& next_aperture_size_mask[SIZE_MASK_WIDTH-1:0];
	end

	// ==========================================================
	// read path
	always_comb begin
		next_cfg_rdata = '0;
		// override forces 1x, otherwise all rates
		next_status_rate = next_port_control_reg[RATE_OVERRIDE_BIT]
			? RATE_1X_ONLY : RATE_ALL;
		if (cfg_read && cfg_offset == PORT_CONTROL_OFFSET) begin
			next_cfg_rdata = port_control_reg;
		end else if (cfg_read && cfg_offset == APERTURE_SIZE_OFFSET) begin
			next_cfg_rdata = {24'h00_0000, aperture_size_mask};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			// control resets zero; mask zero is 256 MB
			port_control_reg          <= PORT_CONTROL_RESET;
			aperture_size_mask        <= APERTURE_SIZE_RESET;
			base_store                <= '0;
			cfg_rdata                 <= '0;
			status_rate               <= RATE_ALL;
			aperture_base_bits        <= '0;
			translation_buffer_enable <= 1'b0;
			lookup_hit                <= 1'b0;
			lookup_page               <= '0;
		end else begin
			port_control_reg          <= next_port_control_reg;
			aperture_size_mask        <= next_aperture_size_mask;
			base_store                <= next_base_store;
			cfg_rdata                 <= next_cfg_rdata;
			status_rate               <= next_status_rate;
			aperture_base_bits        <= next_base_store;
			translation_buffer_enable <=
				next_port_control_reg[TB_ENABLE_BIT];
			lookup_hit                <= tb_hit;
			lookup_page               <= tb_page;
		end
	end

	// ==========================================================
	// translation buffer
	// enable bit drives flush
	translation_buffer u_tb (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.enable     (port_control_reg[TB_ENABLE_BIT]),
		.fill_valid (fill_valid),
		.fill_tag   (fill_tag),
		.fill_page  (fill_page),
		.lookup_tag (lookup_tag),
		.hit        (tb_hit),
		.hit_page   (tb_page),
		.any_valid  (tb_any_valid)
	);

	// ==========================================================
	// checks
	sequence s_ctrl_write;
		cfg_write && cfg_offset == PORT_CONTROL_OFFSET;
	endsequence

	sequence s_size_write;
		cfg_write && cfg_offset == APERTURE_SIZE_OFFSET;
	endsequence

	sequence s_ctrl_read;
		cfg_read && cfg_offset == PORT_CONTROL_OFFSET;
	endsequence

	sequence s_size_read;
		cfg_read && cfg_offset == APERTURE_SIZE_OFFSET;
	endsequence

	// unmapped or idle: read data must fall back to zero
	sequence s_no_read;
		!cfg_read || (cfg_offset != PORT_CONTROL_OFFSET
			&& cfg_offset != APERTURE_SIZE_OFFSET);
	endsequence

	AST_RESET_VALUES: assert property (
		@(posedge sys_clk)
		reset |=> port_control_reg == PORT_CONTROL_RESET
			&& aperture_size_mask == APERTURE_SIZE_RESET
			&& aperture_base_bits == 6'h00
			&& status_rate == RATE_ALL)
	else $error("registers not at reset values");

	AST_CTRL_STORE: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_ctrl_write |=> port_control_reg
			== ($past(cfg_wdata) & PORT_CONTROL_WMASK))
	else $error("control write not stored");

	AST_CTRL_READ: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_ctrl_read |=> cfg_rdata == $past(port_control_reg))
	else $error("control read wrong");

	AST_RESERVED_ZERO: assert property (
		@(posedge sys_clk) disable iff (reset)
		(port_control_reg & ~PORT_CONTROL_WMASK) == 32'h0000_0000
		&& (aperture_size_mask & ~SIZE_MASK_WMASK) == 8'h00)
	else $error("reserved bits set");

	AST_NO_READ_ZERO: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_no_read |=> cfg_rdata == 32'h0000_0000)
	else $error("read data outside a register read");

	AST_OVERRIDE: assert property (
		@(posedge sys_clk) disable iff (reset)
		port_control_reg[RATE_OVERRIDE_BIT]
		|-> status_rate == RATE_1X_ONLY)
	else $error("override not honoured");

	AST_ALL_RATES: assert property (
		@(posedge sys_clk) disable iff (reset)
		!port_control_reg[RATE_OVERRIDE_BIT]
		|-> status_rate == RATE_ALL)
	else $error("rate field wrong");

	AST_SIZE_STORE: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_size_write |=> aperture_size_mask
			== ($past(cfg_wdata[7:0]) & SIZE_MASK_WMASK))
	else $error("size write not stored");

	AST_SIZE_READ: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_size_read |=> cfg_rdata
			== {24'h00_0000, $past(aperture_size_mask)})
	else $error("size read wrong");

	AST_BASE_MASKED: assert property (
		@(posedge sys_clk) disable iff (reset)
		(aperture_base_bits
			& ~aperture_size_mask[SIZE_MASK_WIDTH-1:0]) == 6'h00)
	else $error("masked base bit nonzero");

	AST_BASE_RW: assert property (
		@(posedge sys_clk) disable iff (reset)
		base_write && !cfg_write |=> aperture_base_bits
			== ($past(base_wdata)
			& $past(aperture_size_mask[SIZE_MASK_WIDTH-1:0])))
	else $error("base bit not writable");

	AST_ENABLE_CACHE: assert property (
		@(posedge sys_clk) disable iff (reset)
		port_control_reg[TB_ENABLE_BIT] && fill_valid |=> tb_any_valid)
	else $error("fill ignored while enabled");

	AST_ENABLE_OUT: assert property (
		@(posedge sys_clk) disable iff (reset)
		translation_buffer_enable == port_control_reg[TB_ENABLE_BIT])
	else $error("enable output differs from control bit");

	AST_DISABLE_FLUSH: assert property (
		@(posedge sys_clk) disable iff (reset)
		!port_control_reg[TB_ENABLE_BIT] |=> !tb_any_valid)
	else $error("buffer not flushed");

	AST_NO_HIT_OFF: assert property (
		@(posedge sys_clk) disable iff (reset)
		lookup_hit |-> $past(port_control_reg[TB_ENABLE_BIT]))
	else $error("hit reported while disabled");
endmodule // aperture_control_regs

// >>> hw/translation_buffer.sv
/*
 * small fully associative translation buffer for aperture pages.
 * assumes the table walker supplies fills; disable flushes all entries.
 */
`timescale 1ns/100ps
module translation_buffer
	import aperture_ctrl_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	input  wire logic                     enable,
	input  wire logic                     fill_valid,
	input  wire logic [TB_TAG_WIDTH-1:0]  fill_tag,
	input  wire logic [TB_PAGE_WIDTH-1:0] fill_page,
	input  wire logic [TB_TAG_WIDTH-1:0]  lookup_tag,
	output logic                          hit,
	output logic [TB_PAGE_WIDTH-1:0]      hit_page,
	output logic                          any_valid
);
	logic [TB_ENTRIES-1:0]    valid;
	logic [TB_ENTRIES-1:0]    next_valid;
	logic [TB_TAG_WIDTH-1:0]  tags [TB_ENTRIES];
	logic [TB_PAGE_WIDTH-1:0] pages [TB_ENTRIES];
	logic [TB_IDX_WIDTH-1:0]  victim;
	logic [TB_IDX_WIDTH-1:0]  next_victim;
	logic [TB_ENTRIES-1:0]    match;

	// ==========================================================
	// lookup
	genvar g;
	generate
		for (g = 0; g < TB_ENTRIES; g++) begin : g_match
			assign match[g] = valid[g] && (tags[g] == lookup_tag);
		end
	endgenerate

	always_comb begin
		hit      = enable && (|match);
		hit_page = '0;
		for (int i = 0; i < TB_ENTRIES; i++) begin
			if (match[i]) begin
				hit_page = pages[i];
			end
		end
	end

	assign any_valid = |valid;

	// ==========================================================
	// fill and flush
	always_comb begin
		next_valid  = valid;
		next_victim = victim;
		if (!enable) begin
			next_valid = '0;
		end else if (fill_valid) begin
			next_valid[victim] = 1'b1;
			next_victim        = victim + 3'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			valid  <= '0;
			victim <= '0;
		end else begin
			valid  <= next_valid;
			victim <= next_victim;
		end
	end

	// entry storage needs no reset, valid guards it
	always_ff @(posedge sys_clk) begin
		if (enable && fill_valid) begin
			tags[victim]  <= fill_tag;
			pages[victim] <= fill_page;
		end
	end

	AST_FLUSH_WHEN_OFF: assert property (
		@(posedge sys_clk) disable iff (reset)
		!enable |=> !any_valid)
	else $error("entries survive while disabled");
endmodule // translation_buffer
